/* hdl/ipf_pkg.sv */
// Package of constants for the interrupt priority fields block
package ipf_pkg;
   localparam int unsigned IPF_NUM_SRC = 4;
   localparam int unsigned IPF_ADDR_W = 8;
   localparam int unsigned IPF_DATA_W = 16;
   localparam int unsigned IPF_PRIO_W = 3;
   // Register byte addresses
   localparam logic [7:0] IPF_OFS_PRIO_21 = 8'h00;
   localparam logic [7:0] IPF_OFS_PRIO_22 = 8'h04;
   localparam logic [7:0] IPF_OFS_OSC_TUNE = 8'h08;
   // Source indices
   localparam int unsigned IPF_SRC_SPI3 = 0;
   localparam int unsigned IPF_SRC_TX4 = 1;
   localparam int unsigned IPF_SRC_RX4 = 2;
   localparam int unsigned IPF_SRC_OSC = 3;
   // Field low-bit positions
   localparam int unsigned IPF_POS_SPI3 = 8;
   localparam int unsigned IPF_POS_TX4 = 4;
   localparam int unsigned IPF_POS_RX4 = 0;
   localparam int unsigned IPF_POS_OSC = 8;
   // Encodings and reset values
   localparam logic [2:0] IPF_PRIO_RESET = 3'h4;
   localparam logic [2:0] IPF_PRIO_OFF = 3'h0;
   localparam logic [2:0] IPF_PRIO_LOW = 3'h1;
   localparam logic [2:0] IPF_PRIO_TOP = 3'h7;
   localparam logic [15:0] IPF_RDATA_ZERO = 16'h0000;
endpackage

/* hdl/ipf_priority_fields.sv */
// Priority control fields for four interrupt sources with a register port
`timescale 1ns/100ps
`default_nettype none
module ipf_priority_fields
   import ipf_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [IPF_ADDR_W-1:0] addr_i,
   input wire logic [IPF_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [IPF_DATA_W-1:0] rdata_o,
   input wire logic [IPF_NUM_SRC-1:0] src_req_i,
   output logic [IPF_NUM_SRC-1:0] src_req_o,
   output logic [IPF_PRIO_W-1:0] spi_port3_general_priority_o,
   output logic [IPF_PRIO_W-1:0] serial4_tx_priority_o,
   output logic [IPF_PRIO_W-1:0] serial4_rx_priority_o,
   output logic [IPF_PRIO_W-1:0] osc_selftune_priority_o
);

   typedef struct packed {
      logic [IPF_NUM_SRC-1:0][IPF_PRIO_W-1:0] prio;
      logic [IPF_DATA_W-1:0] rdata;
      logic [IPF_NUM_SRC-1:0] req;
   } ipf_state_type;

   ipf_state_type state_q;
   ipf_state_type state_d;

   ////////////////////////////////////////////////////////////////////////////
   // Level decode: linear, so level equals code

   function automatic logic [IPF_PRIO_W-1:0] ipf_level(input logic [IPF_PRIO_W-1:0] code);
      ipf_level = code;
   endfunction

   function automatic logic ipf_enabled(input logic [IPF_PRIO_W-1:0] code);
      ipf_enabled = (code != IPF_PRIO_OFF);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_d = state_q;
      if (wr_i) begin
         unique case (addr_i)
            IPF_OFS_PRIO_21: begin
               state_d.prio[IPF_SRC_SPI3] = wdata_i[IPF_POS_SPI3 +: IPF_PRIO_W];
               state_d.prio[IPF_SRC_TX4] = wdata_i[IPF_POS_TX4 +: IPF_PRIO_W];
               state_d.prio[IPF_SRC_RX4] = wdata_i[IPF_POS_RX4 +: IPF_PRIO_W];
            end
            IPF_OFS_OSC_TUNE: begin
               state_d.prio[IPF_SRC_OSC] = wdata_i[IPF_POS_OSC +: IPF_PRIO_W];
            end
            default: begin
            end
         endcase
      end
      // Read data stands for one enabled cycle only and holds while ce_i is low; unmapped reads give zero
      state_d.rdata = IPF_RDATA_ZERO;
      if (rd_i) begin
         unique case (addr_i)
            IPF_OFS_PRIO_21: begin
               state_d.rdata[IPF_POS_SPI3 +: IPF_PRIO_W] = state_q.prio[IPF_SRC_SPI3];
               state_d.rdata[IPF_POS_TX4 +: IPF_PRIO_W] = state_q.prio[IPF_SRC_TX4];
               state_d.rdata[IPF_POS_RX4 +: IPF_PRIO_W] = state_q.prio[IPF_SRC_RX4];
            end
            IPF_OFS_OSC_TUNE: begin
               state_d.rdata[IPF_POS_OSC +: IPF_PRIO_W] = state_q.prio[IPF_SRC_OSC];
            end
            default: begin
            end
         endcase
      end
      // Gate requests by the current field; a disabled source is dropped here
      for (int s = 0; s < IPF_NUM_SRC; s++) begin
         state_d.req[s] = src_req_i[s] && ipf_enabled(ipf_level(state_q.prio[s]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset overrides the clock enable

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_q.prio <= {IPF_NUM_SRC{IPF_PRIO_RESET}};
         state_q.rdata <= IPF_RDATA_ZERO;
         state_q.req <= '0;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   assign rdata_o = state_q.rdata;
   assign src_req_o = state_q.req;
   assign spi_port3_general_priority_o = state_q.prio[IPF_SRC_SPI3];
   assign serial4_tx_priority_o = state_q.prio[IPF_SRC_TX4];
   assign serial4_rx_priority_o = state_q.prio[IPF_SRC_RX4];
   assign osc_selftune_priority_o = state_q.prio[IPF_SRC_OSC];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_top_level;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && src_req_i[IPF_SRC_RX4] && serial4_rx_priority_o == IPF_PRIO_TOP && !wr_i)
      |=> (src_req_o[IPF_SRC_RX4] && serial4_rx_priority_o == 3'h7);
   endproperty
   a_top_level: assert property (p_top_level) else $error("top level request lost");

   property p_low_level;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && src_req_i[IPF_SRC_SPI3] && spi_port3_general_priority_o == IPF_PRIO_LOW)
      |=> src_req_o[IPF_SRC_SPI3];
   endproperty
   a_low_level: assert property (p_low_level) else $error("level one request lost");

   property p_disabled;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && osc_selftune_priority_o == IPF_PRIO_OFF) |=> !src_req_o[IPF_SRC_OSC];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled source requested");

   property p_tx_field;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && wr_i && addr_i == IPF_OFS_PRIO_21)
      |=> serial4_tx_priority_o == $past(wdata_i[6:4]);
   endproperty
   a_tx_field: assert property (p_tx_field) else $error("tx field not at bits 6-4");

   property p_osc_read;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && rd_i && addr_i == IPF_OFS_OSC_TUNE)
      |=> (rdata_o[15:11] == 5'h0 && rdata_o[7:0] == 8'h00
           && rdata_o[10:8] == $past(osc_selftune_priority_o));
   endproperty
   a_osc_read: assert property (p_osc_read) else $error("osc register read wrong");

   property p_reset_value;
      @(posedge clk_sys_i)
      reset_i |=> (serial4_tx_priority_o == 3'h4 && osc_selftune_priority_o == 3'h4
                   && spi_port3_general_priority_o == 3'h4 && serial4_rx_priority_o == 3'h4);
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("reset value not four");

   property p_freeze;
      @(posedge clk_sys_i) disable iff (reset_i)
      !ce_i |=> ($stable(src_req_o) && $stable(rdata_o) && $stable(serial4_tx_priority_o));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   // Read data must drop back to zero, or a stale word could pass for a later read
   property p_rdata_idle;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && !rd_i) |=> rdata_o == IPF_RDATA_ZERO;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outlived its cycle");

   // Unused places of register 21 read zero, fields read what they held before the strobe
   property p_reg21_read;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && rd_i && addr_i == IPF_OFS_PRIO_21)
      |=> (rdata_o[15:11] == 5'h00 && rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0
           && rdata_o[10:8] == $past(spi_port3_general_priority_o)
           && rdata_o[6:4] == $past(serial4_tx_priority_o)
           && rdata_o[2:0] == $past(serial4_rx_priority_o));
   endproperty
   a_reg21_read: assert property (p_reg21_read) else $error("register 21 read wrong");

   // Register 22 has no field in this block
   property p_reg22_read;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && rd_i && addr_i == IPF_OFS_PRIO_22) |=> rdata_o == IPF_RDATA_ZERO;
   endproperty
   a_reg22_read: assert property (p_reg22_read) else $error("register 22 read not zero");

   property p_fields_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && wr_i && addr_i == IPF_OFS_PRIO_21)
      |=> (spi_port3_general_priority_o == $past(wdata_i[10:8])
           && serial4_rx_priority_o == $past(wdata_i[2:0]));
   endproperty
   a_fields_write: assert property (p_fields_write) else $error("register 21 fields misplaced");

   property p_osc_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && wr_i && addr_i == IPF_OFS_OSC_TUNE)
      |=> osc_selftune_priority_o == $past(wdata_i[10:8]);
   endproperty
   a_osc_write: assert property (p_osc_write) else $error("osc field not at bits 10-8");

   // A field may only move on a write to its own register; a stray decode would
   // silently retune some other source
   property p_reg21_hold;
      @(posedge clk_sys_i) disable iff (reset_i)
      !(ce_i && wr_i && addr_i == IPF_OFS_PRIO_21)
      |=> ($stable(spi_port3_general_priority_o) && $stable(serial4_tx_priority_o)
           && $stable(serial4_rx_priority_o));
   endproperty
   a_reg21_hold: assert property (p_reg21_hold) else $error("register 21 field moved");

   property p_osc_hold;
      @(posedge clk_sys_i) disable iff (reset_i)
      !(ce_i && wr_i && addr_i == IPF_OFS_OSC_TUNE) |=> $stable(osc_selftune_priority_o);
   endproperty
   a_osc_hold: assert property (p_osc_hold) else $error("osc field moved");

   // Intermediate levels must forward a request just like the end levels
   property p_mid_level;
      @(posedge clk_sys_i) disable iff (reset_i)
      (ce_i && src_req_i[IPF_SRC_TX4] && serial4_tx_priority_o inside {[3'h2:3'h6]})
      |=> src_req_o[IPF_SRC_TX4];
   endproperty
   a_mid_level: assert property (p_mid_level) else $error("mid level request lost");

   property p_reset_out;
      @(posedge clk_sys_i)
      reset_i |=> (src_req_o == '0 && rdata_o == IPF_RDATA_ZERO);
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");

   c_top_req: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      src_req_o[IPF_SRC_RX4] && serial4_rx_priority_o == IPF_PRIO_TOP);
   c_disabled_drop: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      src_req_i[IPF_SRC_OSC] && osc_selftune_priority_o == IPF_PRIO_OFF);
   c_write_read: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_i && addr_i == IPF_OFS_PRIO_21 ##1 rd_i && addr_i == IPF_OFS_PRIO_21);
   c_frozen_write: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      !ce_i && wr_i);
   c_mid_level: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      src_req_o[IPF_SRC_TX4] && serial4_tx_priority_o == 3'h3);

endmodule
`default_nettype wire

/* verif/ipf_priority_fields_tb.sv */
// Self-checking testbench for the interrupt priority fields block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module ipf_priority_fields_tb;
   import ipf_pkg::*;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic [3:0] src_req_i = 4'h0;
   logic [15:0] rdata_o;
   logic [3:0] src_req_o;
   logic [2:0] p0, p1, p2, p3;
   logic [2:0] e [4];
   logic [7:0] a;
   int n_errors = 0;
   int checks = 0;
   ipf_priority_fields i_ipf_priority_fields (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .src_req_i(src_req_i), .src_req_o(src_req_o),
      .spi_port3_general_priority_o(p0), .serial4_tx_priority_o(p1),
      .serial4_rx_priority_o(p2), .osc_selftune_priority_o(p3));
   always #2.5 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////////////////////////
   // Expected read word; unmapped places read zero
   function automatic logic [15:0] rexp(input logic [7:0] ad);
      if (ad == IPF_OFS_PRIO_21) return {5'h00, e[0], 1'b0, e[1], 1'b0, e[2]};
      if (ad == IPF_OFS_OSC_TUNE) return {5'h00, e[3], 8'h00};
      return 16'h0000;
   endfunction
   // Model of a register write; only the mapped fields change
   function automatic void mwr(input logic [7:0] ad, input logic [15:0] d);
      if (ad == IPF_OFS_PRIO_21) begin
         e[0] = d[10:8];
         e[1] = d[6:4];
         e[2] = d[2:0];
      end
      if (ad == IPF_OFS_OSC_TUNE) e[3] = d[10:8];
   endfunction
   task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic en);
      @(posedge clk_sys_i);
      ce_i <= en;
      wr_i <= 1'b1;
      addr_i <= ad;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      ce_i <= 1'b1;
      if (en) mwr(ad, d);
   endtask
   // Write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] ad, input logic [15:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= ad;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      mwr(ad, d);
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 `CHK(rdata_o, rexp(ad))
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= ad;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 `CHK(rdata_o, rexp(ad))
      @(posedge clk_sys_i);
      #1 `CHK(rdata_o, 16'h0000)
   endtask
   // Fields are held still while the request path is sampled
   task automatic chk_all(input logic [3:0] r);
      #1 `CHK({p3, p2, p0}, {e[3], e[2], e[0]})
      `CHK(p1, e[1])
      @(posedge clk_sys_i);
      src_req_i <= r;
      @(posedge clk_sys_i);
      #1 `CHK(src_req_o, r & {|e[3], |e[2], |e[1], |e[0]})
   endtask
   task print_verdict;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      n_errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(75));
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      e = '{4{IPF_PRIO_RESET}};
      chk_all(4'hf);
      rd(IPF_OFS_PRIO_21);
      rd(IPF_OFS_OSC_TUNE);
      // Every code, same value in every field
      for (int c = 0; c < 8; c++) begin
         wr(IPF_OFS_PRIO_21, {5'h00, 3'(c), 1'b1, 3'(c), 1'b1, 3'(c)}, 1'b1);
         wr(IPF_OFS_OSC_TUNE, {5'h1f, 3'(c), 8'hff}, 1'b1);
         chk_all(4'hf);
         `CHK(p2, 3'(c))
         rd(IPF_OFS_PRIO_21);
      end
      // Frozen clock enable drops the write; register 22 holds nothing
      wr(IPF_OFS_PRIO_21, 16'h0712, 1'b0);
      wr(IPF_OFS_PRIO_22, 16'hffff, 1'b1);
      chk_all(4'hf);
      rd(IPF_OFS_PRIO_22);
      for (int i = 0; i < 150; i++) begin
         a = 8'($urandom);
         if (i % 4 != 3) a = 8'(4 * (i % 3));
         wr(a, 16'($urandom), 1'b1);
         chk_all(4'($urandom));
         rd(8'(4 * ($urandom % 3)));
      end
      // Back-to-back strobes on addresses 0, 4 and 8, including register 22, which has no field
      for (int i = 0; i < 12; i++) begin
         wr_rd(8'(4 * ($urandom % 3)), 16'($urandom));
      end
      chk_all(4'($urandom));
      // Reset in mid-run with the clock enable low: reset must still act
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      ce_i <= 1'b0;
      @(posedge clk_sys_i);
      reset_i <= 1'b0;
      ce_i <= 1'b1;
      e = '{4{IPF_PRIO_RESET}};
      chk_all(4'hf);
      print_verdict;
   end
endmodule
`default_nettype wire
